// >>> core/qdrr_defs.svh
/*
  Timing counts, register offsets and field positions of the quad converter
  readback and clear controller. Assumes an 8 ns clock.
*/
`ifndef QDRR_DEFS_SVH
`define QDRR_DEFS_SVH
`define QDRR_CLK_PERIOD_NS 8
`define QDRR_CLEAR_MIN_NS  90
`define QDRR_CLEAR_CYC     ((`QDRR_CLEAR_MIN_NS + `QDRR_CLK_PERIOD_NS - 1) / `QDRR_CLK_PERIOD_NS)
`define QDRR_DV_MAX_NS     180
`define QDRR_DV_CYC        ((`QDRR_DV_MAX_NS + `QDRR_CLK_PERIOD_NS - 1) / `QDRR_CLK_PERIOD_NS)
`define QDRR_DF_MAX_NS     75
`define QDRR_DF_CYC        ((`QDRR_DF_MAX_NS + `QDRR_CLK_PERIOD_NS - 1) / `QDRR_CLK_PERIOD_NS)
`define QDRR_OFF_CTRL      4'h0
`define QDRR_OFF_STATUS    4'h4
`define QDRR_OFF_DATA      4'h8
`define QDRR_CTRL_GO       0
`define QDRR_CTRL_MODE     1
`define QDRR_CTRL_CLEAR    2
`define QDRR_CTRL_CHAN_LO  4
`define QDRR_CTRL_QUAD_LO  8
`define QDRR_ST_BUSY       0
`define QDRR_ST_DONE       1
`define QDRR_ST_INIT       2
`endif

// >>> core/qdrr_pkg.sv
/*
  Types of the quad converter readback and clear controller.
  Assumes the definitions header is compiled alongside.
*/
package qdrr_pkg;
  typedef enum logic [2:0] {
    QDRR_ST_IDLE   = 3'b000,
    QDRR_ST_CLR    = 3'b001,
    QDRR_ST_RSETUP = 3'b010,
    QDRR_ST_RWAIT  = 3'b011,
    QDRR_ST_RFLOAT = 3'b100
  } qdrr_state_t;

  // Pins toward the converter
  typedef struct packed {
    logic       chip_sel_n;
    logic       read_n;
    logic       clear_n;
    logic       mode_word_sel_n;
    logic       transparent_load_n;
    logic       byte_half_sel_n;
    logic       quad_sel_line0_n;
    logic       quad_sel_line1_n;
    logic       quad_sel_line2_n;
    logic       channel_sel_bit0;
    logic       channel_sel_bit1;
  } qdrr_pins_t;

  typedef struct packed {
    qdrr_state_t state;
    logic [7:0]  count;
    qdrr_pins_t  pins;
    logic [11:0] data;
    logic        busy;
    logic        done;
    logic        inited;
    logic        mode_rd;
    logic [3:0]  sel;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        aw_got;
    logic        w_got;
    logic [3:0]  aw_addr;
    logic [31:0] wdata;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } qdrr_regs_t;
endpackage

// >>> core/qdrr_ctrl.sv
/*
  Host controller for readback and clear of a four channel 12-bit converter
  over its strobe driven parallel port, with AXI4-Lite control registers.
  Assumes converter pins are already synchronous to aclk on the output side
  and the data bus is sampled through a two flop synchroniser.
*/
// The AXI4-Lite register port and the register offsets were decided locally.
// Overview of operation
// R1 - Reading a channel code lowers read and chip select with the channel address set.
// R2 - Reading the mode word lowers mode select, quad lines 0 and 1, read and chip select.
// R3 - A clear pulse is held low for at least 90 ns; a software clear starts only while the controller is idle and not busy.
// R4 - The device zeroes all outputs on clear, so the host just issues the pulse.
// R5 - In the wide package clear resets modes and codes inside the device.
// R6 - In the narrow package clear rewrites codes only, inside the device.
// R7 - The port state is unknown until a clear, so one is issued after reset.
// R8 - The power on clear is driven from the controller's own reset release.
// R9 - Software clear and reset clear are merged into the same clear pin.
// R10 - Transparent load is held high since the host reads only here.
// R11 - Unused pins are held at their inactive high level.
// R12 - Chip select goes low only during a controller access to the converter.
// R13 - Readback is a full 12-bit word.
// R14 - The host floats no bus; it waits for the device to release the port.
`timescale 1ns/1ns
`default_nettype none
`include "qdrr_defs.svh"
module qdrr_ctrl
  import qdrr_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [3:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  input  wire logic [11:0] io_data_in,
  output qdrr_pins_t       pins
);
  qdrr_regs_t  r;
  qdrr_regs_t  next_r;
  logic [11:0] io_meta;
  logic [11:0] io_sync;

  // Data bus synchroniser
  // Only the second flop feeds the sequencer
  always_ff @(posedge aclk) begin
    io_meta <= io_data_in;
    io_sync <= io_meta;
  end

  // Next state of controller and bus slave
  always_comb begin
    next_r = r;
    next_r.awready = 1'b0;
    next_r.wready = 1'b0;
    next_r.arready = 1'b0;
    if (s_awvalid && !r.aw_got && !r.awready) begin
      next_r.awready = 1'b1;
      next_r.aw_got = 1'b1;
      next_r.aw_addr = s_awaddr;
    end
    if (s_wvalid && !r.w_got && !r.wready) begin
      next_r.wready = 1'b1;
      next_r.w_got = 1'b1;
      next_r.wdata = s_wdata;
    end
    if (r.bvalid && s_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (r.rvalid && s_rready) begin
      next_r.rvalid = 1'b0;
    end
    // Converter sequencing
    case (r.state)
      QDRR_ST_IDLE: begin
        next_r.pins.chip_sel_n = 1'b1;
        next_r.pins.read_n = 1'b1;
        next_r.pins.clear_n = 1'b1;
      end
      QDRR_ST_CLR: begin
        next_r.pins.clear_n = 1'b0; // R3 R9
        next_r.count = r.count + 8'h01;
        // Pin falls one edge after entry, so a full minimum width
        // of cycles must pass before it may rise again
        if (r.count >= 8'(`QDRR_CLEAR_CYC)) begin
          next_r.pins.clear_n = 1'b1; // R3
          next_r.inited = 1'b1; // R7
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
          next_r.state = QDRR_ST_IDLE;
        end
      end
      QDRR_ST_RSETUP: begin
        // Address first, strobes next cycle
        next_r.pins.chip_sel_n = 1'b0; // R12
        next_r.pins.read_n = 1'b0; // R1 R2
        next_r.count = 8'h00;
        next_r.state = QDRR_ST_RWAIT;
      end
      QDRR_ST_RWAIT: begin
        next_r.count = r.count + 8'h01;
        // Allow access time plus synchroniser depth
        if (r.count >= 8'(`QDRR_DV_CYC + 2)) begin
          next_r.data = io_sync; // R13
          next_r.pins.chip_sel_n = 1'b1;
          next_r.pins.read_n = 1'b1;
          next_r.count = 8'h00;
          next_r.state = QDRR_ST_RFLOAT;
        end
      end
      QDRR_ST_RFLOAT: begin
        next_r.count = r.count + 8'h01;
        if (r.count >= 8'(`QDRR_DF_CYC)) begin // R14
          next_r.pins.mode_word_sel_n = 1'b1;
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
          next_r.state = QDRR_ST_IDLE;
        end
      end
      default: begin
        next_r.state = QDRR_ST_IDLE;
      end
    endcase
    // Register writes once both halves are in
    // Byte lanes are read live; the master holds them until the response
    if (r.aw_got && r.w_got && !r.bvalid) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = 2'b00;
      if (r.aw_addr == `QDRR_OFF_CTRL) begin
        if (r.state == QDRR_ST_IDLE && !r.busy && s_wstrb != 4'h0) begin
          next_r.done = 1'b0;
          if (r.wdata[`QDRR_CTRL_CLEAR]) begin
            next_r.busy = 1'b1;
            next_r.count = 8'h00;
            next_r.state = QDRR_ST_CLR; // R9
          end else if (r.wdata[`QDRR_CTRL_GO]) begin
            next_r.busy = 1'b1;
            next_r.mode_rd = r.wdata[`QDRR_CTRL_MODE];
            next_r.sel = {r.wdata[`QDRR_CTRL_QUAD_LO + 1 -: 2],
                          r.wdata[`QDRR_CTRL_CHAN_LO + 1 -: 2]};
            next_r.pins.channel_sel_bit0 = r.wdata[`QDRR_CTRL_CHAN_LO];
            next_r.pins.channel_sel_bit1 = r.wdata[`QDRR_CTRL_CHAN_LO + 1];
            if (r.wdata[`QDRR_CTRL_MODE]) begin
              // Mode word: quad lines 0 and 1 low, line 2 high
              next_r.pins.mode_word_sel_n = 1'b0; // R2
              next_r.pins.quad_sel_line0_n = 1'b0; // R2
              next_r.pins.quad_sel_line1_n = 1'b0; // R2
              next_r.pins.quad_sel_line2_n = 1'b1;
            end else begin
              // One-hot low quad select for quad values 0 to 2; value 3 selects no line
              next_r.pins.mode_word_sel_n = 1'b1;
              next_r.pins.quad_sel_line0_n = !(r.wdata[`QDRR_CTRL_QUAD_LO +: 2] == 2'd0);
              next_r.pins.quad_sel_line1_n = !(r.wdata[`QDRR_CTRL_QUAD_LO +: 2] == 2'd1);
              next_r.pins.quad_sel_line2_n = !(r.wdata[`QDRR_CTRL_QUAD_LO +: 2] == 2'd2);
            end
            next_r.state = QDRR_ST_RSETUP; // R1
          end
        end else begin
          next_r.bresp = 2'b10;
        end
      end else if (r.aw_addr != `QDRR_OFF_STATUS && r.aw_addr != `QDRR_OFF_DATA) begin
        next_r.bresp = 2'b10;
      end
    end
    // Register reads
    if (s_arvalid && !r.rvalid && !r.arready) begin
      next_r.arready = 1'b1;
      next_r.rvalid = 1'b1;
      next_r.rresp = 2'b00;
      next_r.rdata = 32'h0000_0000;
      if (s_araddr == `QDRR_OFF_CTRL) begin
        // Quad and channel back in the bit places they were written to
        next_r.rdata = {22'h0, r.sel[3:2], 2'b00, r.sel[1:0], 4'h0};
      end else if (s_araddr == `QDRR_OFF_STATUS) begin
        next_r.rdata = {29'h0000_0000, r.inited, r.done, r.busy};
      end else if (s_araddr == `QDRR_OFF_DATA) begin
        next_r.rdata = {20'h0_0000, r.data};
      end else begin
        next_r.rresp = 2'b10;
      end
    end
  end

  // State register; reset starts a power on clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.state <= QDRR_ST_CLR; // R7 R8
      r.busy <= 1'b1;
      r.pins <= '1; // R10 R11
      r.pins.clear_n <= 1'b0; // R8
      r.pins.channel_sel_bit0 <= 1'b0;
      r.pins.channel_sel_bit1 <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign s_awready = r.awready;
  assign s_wready  = r.wready;
  assign s_bvalid  = r.bvalid;
  assign s_bresp   = r.bresp;
  assign s_arready = r.arready;
  assign s_rvalid  = r.rvalid;
  assign s_rdata   = r.rdata;
  assign s_rresp   = r.rresp;
  assign pins      = r.pins;
endmodule // qdrr_ctrl
`default_nettype wire

// >>> testbench/qdrr_ctrl_asserts.sv
/* Pin checker of qdrr_ctrl. Bound by the bench; sees only top ports. */
`timescale 1ns/1ns
`default_nettype none
module qdrr_ctrl_asserts
  import qdrr_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire qdrr_pins_t pins
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Strobe relations on the converter port
  cs_only_read_a: assert property (!pins.chip_sel_n |-> !pins.read_n)
    else $error("select without read");
  read_with_cs_a: assert property ($fell(pins.read_n) |-> !pins.chip_sel_n)
    else $error("read without select");
  strobe_hold_a: assert property ($fell(pins.read_n) |->
    !pins.read_n[*8] ##1 !pins.read_n[*8] ##1 !pins.read_n[*7]) else $error("read short");
  float_gap_a: assert property ($rose(pins.read_n) |->
    pins.read_n[*8] ##1 pins.read_n[*2]) else $error("float gap short");
  mode_quads_a: assert property (!pins.mode_word_sel_n && !pins.read_n |->
    !pins.quad_sel_line0_n && !pins.quad_sel_line1_n && pins.clear_n) else $error("mode read");
  trans_idle_a: assert property (pins.transparent_load_n)
    else $error("transparent low");
  clear_width_a: assert property ($fell(pins.clear_n) |->
    !pins.clear_n[*6] ##1 !pins.clear_n[*6]) else $error("clear short");
  boot_clear_a: assert property ($rose(aresetn) |-> !pins.clear_n[*8])
    else $error("no boot clear");
  // Main scenarios
  cover property ($fell(pins.read_n));
  cover property ($fell(pins.clear_n));
  cover property (!pins.mode_word_sel_n && !pins.read_n);
endmodule // qdrr_ctrl_asserts
`default_nettype wire

// >>> testbench/qdrr_dev_model.sv
/* Converter port model: code and mode readback, clear. Driven by pins. */
`timescale 1ns/1ns
`default_nettype none
module qdrr_dev_model
  import qdrr_pkg::*;
#(parameter logic [11:0] MODE_W = 12'h009, parameter bit WIDE = 1'b0)
(
  input  wire qdrr_pins_t pins,
  output logic [11:0]     io_data
);
  logic [11:0] code [4];
  logic [11:0] last;
  logic [11:0] mode;
  time         t_fall;
  // Codes before any clear
  initial begin
    for (int i = 0; i < 4; i++) code[i] = 12'hC30 | 12'(i);
    last = 12'h000;
    mode = MODE_W;
    t_fall = 0;
  end
  // Long clear rewrites codes to zero volts; a short one sets them all to FFF
  always @(pins.clear_n) begin
    if (!pins.clear_n) t_fall = $time;
    else if ($time - t_fall >= 90) begin
      if (WIDE) mode = 12'h000;
      for (int i = 0; i < 4; i++) code[i] = mode[3*i] ? 12'h800 : 12'h000;
    end else begin
      for (int i = 0; i < 4; i++) code[i] = 12'hFFF;
    end
  end
  // Port gives the selected word while read and select are low, the inverse of the last word given otherwise
  always @* begin
    if (!pins.read_n && !pins.chip_sel_n) begin
      last = !pins.mode_word_sel_n ? mode :
        code[{pins.channel_sel_bit1, pins.channel_sel_bit0}];
      io_data = last;
    end else io_data = ~last;
  end
endmodule // qdrr_dev_model
`default_nettype wire

// >>> testbench/tb_quad_dac_readback_and_reset.sv
/* Bench of qdrr_ctrl: AXI4-Lite master tasks, device model, checker bind. */
`timescale 1ns/1ns
`default_nettype none
module tb_quad_dac_readback_and_reset;
  import qdrr_pkg::*;
  localparam logic [11:0] MW = 12'h009;
  logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [3:0] s_awaddr, s_wstrb, s_araddr;
  logic [31:0] s_wdata, s_rdata, rv, seed, d;
  logic [1:0] s_bresp, s_rresp, rs;
  logic [11:0] io;
  qdrr_pins_t pins;
  int failures, check_count, cyc;
  qdrr_ctrl u_dut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .io_data_in(io), .pins);
  qdrr_dev_model #(.MODE_W(MW)) u_dev (.pins, .io_data(io));
  // Clock and hang limit
  initial begin
    aclk = 1'h0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) if (++cyc == 20000) begin
    failures++;
    end_sim();
  end
  task automatic end_sim();
    if (failures == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // AXI write: address and data together, each released when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] st);
    s_awaddr <= a; s_wdata <= v; s_wstrb <= st;
    s_awvalid <= 1'h1; s_wvalid <= 1'h1; s_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'h0;
      if (s_wready) s_wvalid <= 1'h0;
    end while (!s_bvalid);
    rs = s_bresp; s_bready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [3:0] a);
    s_araddr <= a; s_arvalid <= 1'h1; s_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'h0;
    end while (!s_rvalid);
    rv = s_rdata; rs = s_rresp; s_rready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic poll();
    do rd(4'h4); while (rv[0] !== 1'h0);
  endtask
  // Reset, reads of random channels and modes, clear, refusals
  initial begin
    {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wstrb, s_wdata} = '0;
    seed = 32'h671EE8B5; failures = 0; check_count = 0; cyc = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    poll();
    chk("status", 32'h6, rv);
    for (int n = 0; n < 10; n++) begin
      if (n == 5) begin
        wr(4'h0, 32'h4, 4'hF);
        chk("clear resp", 32'h0, 32'(rs));
        poll();
        chk("clear status", 32'h6, rv);
      end
      d = (xs() & 32'h132) | 32'h1;
      wr(4'h0, d, 4'hF);
      chk("go resp", 32'h0, 32'(rs));
      wr(4'h0, d, 4'hF);
      chk("busy resp", 32'h2, 32'(rs));
      poll();
      rd(4'h8);
      chk("code", d[1] ? 32'(MW) : (MW[3*d[5:4]] ? 32'h800 : 32'h0), rv);
      chk("code resp", 32'h0, 32'(rs));
      rd(4'h0);
      chk("ctrl", d & 32'h330, rv);
    end
    wr(4'h0, 32'h1, 4'h0);
    chk("no strobe", 32'h2, 32'(rs));
    wr(4'hC, 32'h1, 4'hF);
    chk("unmapped wr", 32'h2, 32'(rs));
    rd(4'hC);
    chk("unmapped rd data", 32'h0, rv);
    chk("unmapped rd resp", 32'h2, 32'(rs));
    end_sim();
  end
endmodule // tb_quad_dac_readback_and_reset
bind qdrr_ctrl qdrr_ctrl_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .pins(pins));
`default_nettype wire
